// file: logic/half_bridge_gate_sequencer.v
`timescale 1ns/1ps
// How it works
// - boost below stop level ends switching, stop while low side conducts
// - restart only once boost rises above start level; hysteresis between
// - divide-by-two alternates high and low gate each oscillator cycle
// - turn-on moment decided by node slope sensing, no fixed dead time
// - turn-off moment decided by oscillator signal for both gates
// - switching starts only while every enable and protection permits, and runs on until the low side conducts
// - after turn-off, opposite gate turns on when node slope ends
// - built-in minimum dead time, at most 160 ns, between gates
// - slope longer than oscillator charge phase forces next gate on
// - in capacitive mode wait for slope start, oscillator kept slow
// - slope never starting: force on when slowed oscillator tops out
// - no slope 690 ns after turn-off flags capacitive, strong discharge
// - low charge current after turn-off until node slope start seen
// - dead time never alters the oscillator signal
// - period measured between successive turn-offs incl. slow charge
// - low side kept on while disabled through soft-start enable node
`include "hb_seq_defines.vh"

module half_bridge_gate_sequencer #(
  parameter MIN_DEAD = `MIN_DEAD_CYC,
  parameter NO_SLOPE = `NO_SLOPE_CYC
) (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire boost_above_stop,
  input  wire boost_above_start,
  input  wire softstart_enable_ok,
  input  wire protect_ok,
  input  wire slope_start,
  input  wire slope_end,
  input  wire osc_at_high,
  input  wire osc_at_low,
  output reg  high_side_gate,
  output reg  low_side_gate,
  output reg  osc_slow_charge,
  output reg  capacitive_mode,
  output reg  cmr_discharge,
  output reg  turn_off_pulse
);

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam NIN = 6;
  wire [NIN-1:0] raw_in;
  reg  [NIN-1:0] sync1_q;
  reg  [NIN-1:0] sync2_q;
  assign raw_in = {osc_at_low, osc_at_high, slope_end, slope_start,
                   boost_above_start, boost_above_stop};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  wire b_stop  = sync2_q[0];
  wire b_start = sync2_q[1];
  wire s_start = sync2_q[2];
  wire s_end   = sync2_q[3];
  wire o_high  = sync2_q[4];
  wire o_low   = sync2_q[5];

  // ****************************************
  // undervoltage guard with hysteresis
  // ****************************************
  reg boost_ok_q;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      boost_ok_q <= 1'b0;
    end else if (!b_stop) begin
      boost_ok_q <= 1'b0;
    end else if (b_start) begin
      boost_ok_q <= 1'b1;
    end
  end
  wire run_ok = boost_ok_q & softstart_enable_ok & protect_ok;

  // ****************************************
  // oscillator edge detect
  // ****************************************
  reg o_high_q;
  reg o_low_q;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      o_high_q <= 1'b0;
      o_low_q  <= 1'b0;
    end else begin
      o_high_q <= o_high;
      o_low_q  <= o_low;
    end
  end
  wire o_high_rise = o_high & ~o_high_q;
  wire o_low_rise  = o_low & ~o_low_q;
  // either oscillator turning point ends the conducting stroke
  wire osc_turn    = o_high_rise | o_low_rise;

  // ****************************************
  // sequencer
  // ****************************************
  reg [2:0]          st_q;
  reg [2:0]          st_d;
  reg                hs_sel_q;
  reg [`TMR_W-1:0]   tmr_q;
  reg                seen_start_q;
  reg                hs_d;
  reg                ls_d;
  // leave dead state early so both gates are off at least MIN_DEAD cycles
  localparam [`TMR_W-1:0] DEAD_EXIT = MIN_DEAD[`TMR_W-1:0] - `DEAD_LAT;

  always @* begin
    st_d = st_q;
    hs_d = high_side_gate;
    ls_d = low_side_gate;
    case (st_q)
      `ST_STOP: begin
        hs_d = 1'b0;
        ls_d = 1'b1;
        if (run_ok) begin
          st_d = `ST_ON;
        end
      end
      `ST_ON: begin
        if (osc_turn) begin
          hs_d = 1'b0;
          ls_d = 1'b0;
          st_d = `ST_DEAD;
        end
        if (!run_ok && low_side_gate) begin
          hs_d = 1'b0;
          ls_d = 1'b1;
          st_d = `ST_STOP;
        end
      end
      `ST_DEAD: begin
        if (tmr_q >= DEAD_EXIT) begin
          st_d = `ST_WAIT;
        end
      end
      `ST_WAIT: begin
        // slope end; charge phase over; slowed osc at top
        if ((seen_start_q && s_end) || (seen_start_q && osc_turn) ||
            (!seen_start_q && o_high_rise)) begin
          st_d = `ST_NEXT;
        end
      end
      `ST_NEXT: begin
        hs_d = hs_sel_q;
        ls_d = ~hs_sel_q;
        st_d = `ST_ON;
        if (!run_ok && !hs_sel_q) begin
          st_d = `ST_STOP;
        end
      end
      default: begin
        st_d = `ST_STOP;
        hs_d = 1'b0;
        ls_d = 1'b1;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q           <= `ST_STOP;
      hs_sel_q       <= 1'b1;
      tmr_q          <= {`TMR_W{1'b0}};
      seen_start_q   <= 1'b0;
      high_side_gate <= 1'b0;
      low_side_gate  <= 1'b1;
      osc_slow_charge <= 1'b0;
      capacitive_mode <= 1'b0;
      cmr_discharge  <= 1'b0;
      turn_off_pulse <= 1'b0;
    end else begin
      st_q           <= st_d;
      high_side_gate <= hs_d;
      low_side_gate  <= ls_d;
      turn_off_pulse <= (st_q == `ST_ON) && (st_d == `ST_DEAD);
      // once a gate has been driven, the other one is next
      if (st_q == `ST_NEXT) begin
        hs_sel_q <= ~hs_sel_q;
      end
      if ((st_q == `ST_ON) && (st_d == `ST_DEAD)) begin
        tmr_q           <= {`TMR_W{1'b0}};
        seen_start_q    <= 1'b0;
        osc_slow_charge <= 1'b1;
      end else begin
        if (tmr_q != {`TMR_W{1'b1}}) begin
          tmr_q <= tmr_q + 1'b1;
        end
        if ((st_q == `ST_DEAD || st_q == `ST_WAIT) && s_start) begin
          seen_start_q    <= 1'b1;
          osc_slow_charge <= 1'b0;
        end else if (st_q == `ST_STOP) begin
          osc_slow_charge <= 1'b0;
        end
      end
      // flag and strong discharge until the slope starts
      if ((st_q == `ST_DEAD || st_q == `ST_WAIT) && !seen_start_q &&
          !s_start && tmr_q >= NO_SLOPE[`TMR_W-1:0]) begin
        capacitive_mode <= 1'b1;
        cmr_discharge   <= 1'b1;
      end else if (s_start || st_q == `ST_STOP) begin
        capacitive_mode <= 1'b0;
        cmr_discharge   <= 1'b0;
      end
    end
  end
  // oscillator inputs are only observed, never driven from gate timing
endmodule

// file: logic/hb_seq_defines.vh
`ifndef HB_SEQ_DEFINES_VH
`define HB_SEQ_DEFINES_VH
// core clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS      5000
// minimum non-overlap time, ns (upper bound of the built-in figure)
`define MIN_DEAD_NS        160
// most cycles that still stay within 160 ns (longest time rounds down)
`define MIN_DEAD_CYC       ((`MIN_DEAD_NS * 1000) / `CLK_PERIOD_PS)
// no-slope time before capacitive mode is flagged, ns
`define NO_SLOPE_NS        690
`define NO_SLOPE_CYC \
  ((`NO_SLOPE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// cycles from dead-state exit decision to the gate flop turning on
`define DEAD_LAT           8'h03
// counter width for the timers
`define TMR_W              8
// sequencer states
`define ST_STOP            3'h0
`define ST_ON              3'h1
`define ST_DEAD            3'h2
`define ST_WAIT            3'h3
`define ST_NEXT            3'h4
`endif

// file: testbench/half_bridge_gate_sequencer_tb_top.sv
`timescale 1ns/1ps
// ****
// testbench top
// ****
module half_bridge_gate_sequencer_tb_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, no_slope = 1'b0;
  logic boost_above_stop = 1'b1, boost_above_start = 1'b1;
  logic softstart_enable_ok = 1'b1, protect_ok = 1'b1;
  logic slope_start, slope_end, osc_at_high, osc_at_low;
  logic high_side_gate, low_side_gate, osc_slow_charge;
  logic capacitive_mode, cmr_discharge, turn_off_pulse;
  int   err_total = 0, n_tests = 0;
  half_bridge_gate_sequencer half_bridge_gate_sequencer_inst (.clk_sys,
    .rst_n, .boost_above_stop, .boost_above_start, .softstart_enable_ok,
    .protect_ok, .slope_start, .slope_end, .osc_at_high, .osc_at_low,
    .high_side_gate, .low_side_gate, .osc_slow_charge, .capacitive_mode,
    .cmr_discharge, .turn_off_pulse);
  hb_bridge_model hb_bridge_model_inst (.clk_sys, .high_side_gate,
    .low_side_gate, .no_slope, .slope_start, .slope_end, .osc_at_high,
    .osc_at_low);
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic chk(logic got, logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d compares %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // sel 0 high gate, 1 turn off pulse, 2 either gate
  task automatic wait_for(int sel, int n);
    int i;
    logic s;
    for (i = 0; i < n; i++) begin
      s = sel == 0 ? high_side_gate : sel == 1 ? turn_off_pulse
        : high_side_gate | low_side_gate;
      if (s === 1'b1) return;
      @(posedge clk_sys) #1;
    end
    err_total++;
    summarize();
  endtask
  task automatic t_alt;
    int d;
    wait_for(0, 1000);
    chk(low_side_gate, 1'b0);
    wait_for(1, 400);
    for (d = 0; d < 400 && (high_side_gate | low_side_gate) !== 1'b1; d++)
      @(posedge clk_sys) #1;
    chk(d >= 32, 1'b1);
    chk(d < 400, 1'b1);
    chk(low_side_gate, 1'b1);
  endtask
  task automatic t_cap;
    @(posedge clk_sys) no_slope <= 1'b1;
    wait_for(1, 400);
    repeat (145) @(posedge clk_sys);
    #1;
    chk(capacitive_mode, 1'b1);
    chk(osc_slow_charge, 1'b1);
    wait_for(2, 500);
    @(posedge clk_sys) no_slope <= 1'b0;
    wait_for(1, 400);
    repeat (20) @(posedge clk_sys);
    #1;
    chk(cmr_discharge, 1'b0);
  endtask
  task automatic t_uv;
    @(posedge clk_sys) boost_above_stop <= 1'b0;
    boost_above_start <= 1'b0;
    repeat (600) @(posedge clk_sys);
    boost_above_stop <= 1'b1;
    #1;
    chk(low_side_gate, 1'b1);
    repeat (600) @(posedge clk_sys);
    boost_above_start <= 1'b1;
    #1;
    chk(high_side_gate, 1'b0);
    wait_for(0, 1000);
  endtask
  task automatic t_inh;
    @(posedge clk_sys) softstart_enable_ok <= 1'b0;
    repeat (600) @(posedge clk_sys);
    softstart_enable_ok <= 1'b1;
    protect_ok <= 1'b0;
    #1;
    chk(low_side_gate, 1'b1);
    repeat (600) @(posedge clk_sys);
    protect_ok <= 1'b1;
    #1;
    chk(high_side_gate, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_alt();
    t_cap();
    t_uv();
    t_inh();
    summarize();
  end
endmodule
bind half_bridge_gate_sequencer hb_seq_chk #(.MIN_DEAD(MIN_DEAD)) chk_inst (
  .clk_sys, .rst_n, .boost_above_stop, .protect_ok, .high_side_gate,
  .low_side_gate, .osc_slow_charge, .capacitive_mode, .cmr_discharge,
  .turn_off_pulse);

// file: testbench/hb_bridge_model.sv
`timescale 1ns/1ps
// ****
// bridge node and oscillator model
// ****
module hb_bridge_model #(
  parameter OSC_P = 400
) (
  input  wire  clk_sys,
  input  wire  high_side_gate,
  input  wire  low_side_gate,
  input  wire  no_slope,
  output logic slope_start,
  output logic slope_end,
  output logic osc_at_high,
  output logic osc_at_low
);
  int osc_q = 0;
  int off_q = 0;
  always @(posedge clk_sys) begin
    osc_q <= (osc_q == OSC_P - 1) ? 0 : osc_q + 1;
    off_q <= (high_side_gate || low_side_gate) ? 0 : off_q + 1;
  end
  // node swings only while both gates are off
  assign slope_start = !no_slope && off_q >= 3;
  assign slope_end   = !no_slope && off_q >= 40;
  assign osc_at_high = osc_q >= OSC_P / 2 - 4 && osc_q < OSC_P / 2;
  assign osc_at_low  = osc_q >= OSC_P - 4;
endmodule

// file: testbench/hb_seq_chk.sv
`timescale 1ns/1ps
// ****
// sequencer checks
// ****
module hb_seq_chk #(
  parameter MIN_DEAD = 32
) (
  input wire clk_sys,
  input wire rst_n,
  input wire boost_above_stop,
  input wire protect_ok,
  input wire high_side_gate,
  input wire low_side_gate,
  input wire osc_slow_charge,
  input wire capacitive_mode,
  input wire cmr_discharge,
  input wire turn_off_pulse
);
  logic [15:0] dead_q;
  logic [2:0]  uv_run_q;
  logic        uv_park_q;
  logic        pr_park_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence both_off;
    !high_side_gate && !low_side_gate;
  endsequence
  // cycles in a row with both gates off
  always @(posedge clk_sys) begin
    if (!rst_n || high_side_gate || low_side_gate) dead_q <= 16'h0000;
    else if (dead_q != 16'hFFFF) dead_q <= dead_q + 16'h0001;
  end
  // parked: inhibit has reached the sequencer while the low side conducts
  always @(posedge clk_sys) begin
    if (!rst_n || boost_above_stop) begin
      uv_run_q  <= 3'h0;
      uv_park_q <= 1'b0;
    end else begin
      if (uv_run_q != 3'h7) uv_run_q <= uv_run_q + 3'h1;
      if (uv_run_q >= 3'h3 && low_side_gate) uv_park_q <= 1'b1;
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_n || protect_ok) pr_park_q <= 1'b0;
    else if (low_side_gate) pr_park_q <= 1'b1;
  end
  no_overlap_a: assert property (!(high_side_gate && low_side_gate))
    else $error("gates overlap");
  dead_min_a: assert property (
    $rose(high_side_gate) || $rose(low_side_gate) |-> dead_q >= MIN_DEAD)
    else $error("dead time too short");
  uv_block_a: assert property (uv_park_q |-> !high_side_gate)
    else $error("high gate on in undervoltage");
  prot_block_a: assert property (pr_park_q |-> !high_side_gate)
    else $error("high gate on while inhibited");
  cap_discharge_a: assert property (capacitive_mode |-> cmr_discharge)
    else $error("capacitive flag without discharge");
  slow_after_off_a: assert property (turn_off_pulse
    |-> osc_slow_charge and both_off) else $error("no slow charge at off");
  pulse_single_a: assert property (turn_off_pulse |=> !turn_off_pulse)
    else $error("turn off pulse too long");
  off_cause_a: assert property (turn_off_pulse |-> $past(high_side_gate)
    || $past(low_side_gate) || $past(high_side_gate, 2)
    || $past(low_side_gate, 2)) else $error("pulse without gate off");
endmodule
